//--- hw/pin_mux_pkg.sv
// Package for the parallel and host pin multiplexers.
// Assumes a single clock domain and an asynchronous active-low reset.
package pin_mux_pkg;

  localparam int addr_pins = 20;
  localparam int data_pins = 32;
  localparam int ctl_pins = 16;
  localparam int host_data_w = 8;
  localparam int host_ctl_w = 2;
  localparam int io_w = 46;

  // Position of the fields of the parallel I/O word
  localparam int io_addr_lsb = 0;
  localparam int io_addr_w = 4;
  localparam int io_data_lsb = 4;
  localparam int io_data_w = 16;
  localparam int io_ctl_lsb = 20;
  localparam int io_hdata_lsb = 36;
  localparam int io_hctl_lsb = 44;

  // Address pin index 0 stands for A2; GPIO takes pins A21..A18
  localparam int addr_io_lsb = 16;
  localparam int data_io_lsb = 16;

  // Control pin positions in memory mode
  localparam int ctl_read = 0;
  localparam int ctl_oe = 1;
  localparam int ctl_write = 2;
  localparam int ctl_ready = 3;
  localparam int ctl_cs_lsb = 4;
  localparam int ctl_be_lsb = 8;
  localparam int ctl_cke = 12;
  localparam int ctl_sync_out_enable_space3 = 13;
  localparam int ctl_hold = 14;
  localparam int ctl_hold_ack = 15;
  localparam int host_ctl_strobe = 0;
  localparam int host_ctl_byte_ident = 1;

  localparam logic mode_gpio = 1'b0;
  localparam logic mode_mem = 1'b1;
  localparam logic mode_reset = 1'b0;

  // One direction group: value driven out and output enable for each pin
  typedef struct packed {
    logic [addr_pins-1:0] addr_out;
    logic [addr_pins-1:0] addr_oe;
    logic [data_pins-1:0] data_out;
    logic [data_pins-1:0] data_oe;
    logic [ctl_pins-1:0] ctl_out;
    logic [ctl_pins-1:0] ctl_oe;
  } par_drive_t;

  typedef struct packed {
    logic [host_data_w-1:0] data_out;
    logic [host_data_w-1:0] data_oe;
    logic [host_ctl_w-1:0] ctl_out;
    logic [host_ctl_w-1:0] ctl_oe;
  } host_drive_t;

  typedef struct packed {
    logic [io_w-1:0] out;
    logic [io_w-1:0] oe;
  } io_drive_t;

endpackage : pin_mux_pkg

//--- hw/mode_capture.sv
// Strap capture for the pin multiplexers.
// Assumes the strap pin is asynchronous to clk and steady around reset release.
module mode_capture
  import pin_mux_pkg::*;
(
  input wire logic clk,
  input wire logic rst_n,
  input wire logic mode_strap_pin,
  output logic mode
);

  logic sync_a;
  logic sync_b;
  logic fill_a;
  logic fill_b;
  logic taken;
  logic next_taken;
  logic next_mode;

  always_comb
  begin
    // Capture only once the synchroniser holds a level sampled after release
    next_taken = taken | fill_b;
    next_mode = mode;
    if (fill_b && !taken)
    begin
      next_mode = sync_b; // see (R3) (R18)
    end
  end

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      sync_a <= 1'b0;
      sync_b <= 1'b0;
      fill_a <= 1'b0;
      fill_b <= 1'b0;
      taken <= 1'b0;
      mode <= mode_reset;
    end
    else
    begin
      sync_a <= mode_strap_pin;
      sync_b <= sync_a;
      fill_a <= 1'b1;
      fill_b <= fill_a;
      taken <= next_taken;
      mode <= next_mode;
    end
  end

endmodule : mode_capture

//--- hw/parallel_host_pin_mux.sv
// Parallel port and host port pin multiplexers with a shared strap-chosen mode.
// Assumes pad cells resolve pins from out/oe; internal memory, host and I/O logic sit on clk.
//////////////////////////////////////////////////////////////////////////////
// Notes on behaviour
// (R1) Parallel mux governs 20 address, 32 data and 16 control pins.
// (R2) Host mux governs 8 data and 2 control pins.
// (R3) Strap low at reset picks I/O mode; high picks memory plus host port.
// (R4) I/O mode disables memory and host ports; 36 parallel pins become I/O.
// (R5) I/O mode: address 17..2 and data 15..0 are reserved.
// (R6) I/O mode: A21..18 to bits 3..0, D31..16 to 19..4, controls to 20..35.
// (R7) Strap low clears the shared mode bit.
// (R8) Memory mode ties address and data pins straight to the memory port.
// (R9) Memory mode control pins carry strobes, selects, lanes, clock enable, hold.
// (R10) Strap high sets the mode bit and enables the multiplexed host port.
// (R11) Host address and data share the eight host data pins in sequence.
// (R12) Host mode: data to port bits, ctl0 address strobe, ctl1 byte ident.
// (R13) I/O mode: host data to bits 43..36, ctl0 to 44, ctl1 to 45.
// (R14) Mode bit reads 0 when host mux is in I/O mode.
// (R15) Mode bit reads 1 when host mux is in multiplexed mode.
// (R16) Software must not change the mode after reset release.
// (R17) Memory port clock is gated off unless memory mode is selected.
// (R18) Strap is captured once at reset release and held until next reset.
// (R19) Reserved pins are not driven and their inputs are ignored.
module parallel_host_pin_mux
  import pin_mux_pkg::*;
(
  input wire logic clk,
  input wire logic rst_n,
  input wire logic mode_strap_pin,
  // Pins as seen by the pads
  input wire logic [addr_pins-1:0] addr_pin_in,
  input wire logic [data_pins-1:0] data_pin_in,
  input wire logic [ctl_pins-1:0] ctl_pin_in,
  input wire logic [host_data_w-1:0] host_data_pins_in,
  input wire logic [host_ctl_w-1:0] host_ctl_pins_in,
  output par_drive_t par_pins,
  output host_drive_t host_pins,
  // Memory port side
  input wire par_drive_t external_memory_port_drive,
  output logic [addr_pins-1:0] mem_addr_in,
  output logic [data_pins-1:0] mem_data_in,
  output logic [ctl_pins-1:0] mem_ctl_in,
  output logic external_memory_port_clk_en,
  // Host port side
  input wire logic [host_data_w-1:0] host_port_data_out,
  input wire logic [host_data_w-1:0] host_port_data_oe,
  output logic [host_data_w-1:0] host_port_data_in,
  output logic host_addr_strobe,
  output logic host_byte_ident,
  output logic host_port_en,
  // Parallel I/O side
  input wire io_drive_t parallel_io_drive,
  output logic [io_w-1:0] parallel_io_bits,
  // Shared mode bit of the bus select register
  output logic bus_select_reg
);

  logic mode;
  logic [addr_pins-1:0] addr_s1;
  logic [addr_pins-1:0] addr_s2;
  logic [data_pins-1:0] data_s1;
  logic [data_pins-1:0] data_s2;
  logic [ctl_pins-1:0] ctl_s1;
  logic [ctl_pins-1:0] ctl_s2;
  logic [host_data_w-1:0] hdata_s1;
  logic [host_data_w-1:0] hdata_s2;
  logic [host_ctl_w-1:0] hctl_s1;
  logic [host_ctl_w-1:0] hctl_s2;
  logic [addr_pins-1:0] next_addr_s1;
  logic [addr_pins-1:0] next_addr_s2;
  logic [data_pins-1:0] next_data_s1;
  logic [data_pins-1:0] next_data_s2;
  logic [ctl_pins-1:0] next_ctl_s1;
  logic [ctl_pins-1:0] next_ctl_s2;
  logic [host_data_w-1:0] next_hdata_s1;
  logic [host_data_w-1:0] next_hdata_s2;
  logic [host_ctl_w-1:0] next_hctl_s1;
  logic [host_ctl_w-1:0] next_hctl_s2;

  par_drive_t next_par;
  host_drive_t next_host;
  logic [addr_pins-1:0] next_mem_addr;
  logic [data_pins-1:0] next_mem_data;
  logic [ctl_pins-1:0] next_mem_ctl;
  logic [host_data_w-1:0] next_hp_data;
  logic next_has;
  logic next_host_byte_ident;
  logic [io_w-1:0] next_io;

  //////////////////////////////////////////////////////////////////////////////
  mode_capture u_mode_capture (
    .clk(clk),
    .rst_n(rst_n),
    .mode_strap_pin(mode_strap_pin),
    .mode(mode)
  );

  //////////////////////////////////////////////////////////////////////////////
  // Pin input synchronisers
  always_comb
  begin
    next_addr_s1 = addr_pin_in;
    next_addr_s2 = addr_s1;
    next_data_s1 = data_pin_in;
    next_data_s2 = data_s1;
    next_ctl_s1 = ctl_pin_in;
    next_ctl_s2 = ctl_s1;
    next_hdata_s1 = host_data_pins_in;
    next_hdata_s2 = hdata_s1;
    next_hctl_s1 = host_ctl_pins_in;
    next_hctl_s2 = hctl_s1;
  end

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      addr_s1 <= '0;
      addr_s2 <= '0;
      data_s1 <= '0;
      data_s2 <= '0;
      ctl_s1 <= '0;
      ctl_s2 <= '0;
      hdata_s1 <= '0;
      hdata_s2 <= '0;
      hctl_s1 <= '0;
      hctl_s2 <= '0;
    end
    else
    begin
      addr_s1 <= next_addr_s1;
      addr_s2 <= next_addr_s2;
      data_s1 <= next_data_s1;
      data_s2 <= next_data_s2;
      ctl_s1 <= next_ctl_s1;
      ctl_s2 <= next_ctl_s2;
      hdata_s1 <= next_hdata_s1;
      hdata_s2 <= next_hdata_s2;
      hctl_s1 <= next_hctl_s1;
      hctl_s2 <= next_hctl_s2;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Routing
  always_comb
  begin
    next_par = '0; // see (R19)
    next_host = '0;
    next_mem_addr = '0;
    next_mem_data = '0;
    next_mem_ctl = '0;
    next_hp_data = '0;
    next_has = 1'b0;
    next_host_byte_ident = 1'b0;
    next_io = '0;
    if (mode == mode_mem)
    begin
      next_par = external_memory_port_drive; // see (R1) (R8) (R9)
      next_mem_addr = addr_s2; // see (R8)
      next_mem_data = data_s2;
      next_mem_ctl = ctl_s2; // see (R9)
      next_host.data_out = host_port_data_out; // see (R2) (R11) (R12)
      next_host.data_oe = host_port_data_oe;
      next_hp_data = hdata_s2; // see (R12)
      next_has = hctl_s2[host_ctl_strobe];
      next_host_byte_ident = hctl_s2[host_ctl_byte_ident];
    end
    else
    begin
      // Reserved address and data pins stay undriven and unread; see (R4) (R5)
      next_par.addr_out[addr_pins-1 -: io_addr_w] =
        parallel_io_drive.out[io_addr_lsb +: io_addr_w]; // see (R6)
      next_par.addr_oe[addr_pins-1 -: io_addr_w] =
        parallel_io_drive.oe[io_addr_lsb +: io_addr_w];
      next_par.data_out[data_pins-1 -: io_data_w] =
        parallel_io_drive.out[io_data_lsb +: io_data_w];
      next_par.data_oe[data_pins-1 -: io_data_w] =
        parallel_io_drive.oe[io_data_lsb +: io_data_w];
      next_par.ctl_out = parallel_io_drive.out[io_ctl_lsb +: ctl_pins];
      next_par.ctl_oe = parallel_io_drive.oe[io_ctl_lsb +: ctl_pins];
      next_io[io_addr_lsb +: io_addr_w] = addr_s2[addr_io_lsb +: io_addr_w];
      next_io[io_data_lsb +: io_data_w] = data_s2[data_io_lsb +: io_data_w];
      next_io[io_ctl_lsb +: ctl_pins] = ctl_s2;
      next_host.data_out = parallel_io_drive.out[io_hdata_lsb +: host_data_w]; // see (R13)
      next_host.data_oe = parallel_io_drive.oe[io_hdata_lsb +: host_data_w];
      next_host.ctl_out = parallel_io_drive.out[io_hctl_lsb +: host_ctl_w];
      next_host.ctl_oe = parallel_io_drive.oe[io_hctl_lsb +: host_ctl_w];
      next_io[io_hdata_lsb +: host_data_w] = hdata_s2;
      next_io[io_hctl_lsb +: host_ctl_w] = hctl_s2;
    end
  end

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      par_pins <= '0;
      host_pins <= '0;
      mem_addr_in <= '0;
      mem_data_in <= '0;
      mem_ctl_in <= '0;
      host_port_data_in <= '0;
      host_addr_strobe <= 1'b0;
      host_byte_ident <= 1'b0;
      parallel_io_bits <= '0;
      external_memory_port_clk_en <= 1'b0;
      host_port_en <= 1'b0;
      bus_select_reg <= mode_reset;
    end
    else
    begin
      par_pins <= next_par;
      host_pins <= next_host;
      mem_addr_in <= next_mem_addr;
      mem_data_in <= next_mem_data;
      mem_ctl_in <= next_mem_ctl;
      host_port_data_in <= next_hp_data;
      host_addr_strobe <= next_has;
      host_byte_ident <= next_host_byte_ident;
      parallel_io_bits <= next_io;
      external_memory_port_clk_en <= mode; // see (R17) (R4)
      host_port_en <= mode; // see (R10) (R4)
      bus_select_reg <= mode; // see (R7) (R10) (R14) (R15)
    end
  end

endmodule : parallel_host_pin_mux

//--- verif/parallel_host_pin_mux_asserts.sv
// Checker for the parallel and host pin multiplexers.
// Assumes only the top module's ports; bound below.
module parallel_host_pin_mux_asserts
  import pin_mux_pkg::*;
(
  input wire logic clk,
  input wire logic rst_n,
  input wire par_drive_t par_pins,
  input wire host_drive_t host_pins,
  input wire par_drive_t external_memory_port_drive,
  input wire logic [host_data_w-1:0] host_port_data_oe,
  input wire io_drive_t parallel_io_drive,
  input wire logic [io_w-1:0] parallel_io_bits,
  input wire logic external_memory_port_clk_en,
  input wire logic host_port_en,
  input wire logic bus_select_reg
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [3:0] up_cnt;
  logic [3:0] next_up_cnt;
  logic settled;
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);
  // Mode is captured a few edges after release; judge only once it has landed
  assign settled = (up_cnt == 4'hf);
  assign next_up_cnt = settled ? up_cnt : up_cnt + 4'h1;
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      up_cnt <= 4'h0;
    end
    else
    begin
      up_cnt <= next_up_cnt;
    end
  end
  chk_mode_report: assert property (settled |-> host_port_en == bus_select_reg
    && external_memory_port_clk_en == bus_select_reg) else $error("mode outputs disagree");
  chk_mode_hold: assert property (settled |-> $stable(bus_select_reg))
    else $error("mode changed after capture");
  chk_io_addr_map: assert property (settled && !bus_select_reg |->
    par_pins.addr_out == {$past(parallel_io_drive.out[3:0]), 16'h0}
    && par_pins.addr_oe == {$past(parallel_io_drive.oe[3:0]), 16'h0})
    else $error("io address map");
  chk_io_data_map: assert property (settled && !bus_select_reg |->
    par_pins.data_out == {$past(parallel_io_drive.out[19:4]), 16'h0}
    && par_pins.data_oe == {$past(parallel_io_drive.oe[19:4]), 16'h0}
    && par_pins.ctl_out == $past(parallel_io_drive.out[35:20])
    && par_pins.ctl_oe == $past(parallel_io_drive.oe[35:20])) else $error("io data map");
  chk_host_io_map: assert property (settled && !bus_select_reg |->
    host_pins == {$past(parallel_io_drive.out[43:36]), $past(parallel_io_drive.oe[43:36]),
    $past(parallel_io_drive.out[45:44]), $past(parallel_io_drive.oe[45:44])})
    else $error("host io map");
  chk_mem_pass: assert property (settled && bus_select_reg |->
    par_pins == $past(external_memory_port_drive)) else $error("memory pass");
  chk_host_mem: assert property (settled && bus_select_reg |->
    host_pins.data_oe == $past(host_port_data_oe) && host_pins.ctl_oe == 2'h0)
    else $error("host port map");
  chk_unsel_zero: assert property (settled && bus_select_reg |->
    parallel_io_bits == 46'h0) else $error("io bits live");
endmodule : parallel_host_pin_mux_asserts
bind parallel_host_pin_mux parallel_host_pin_mux_asserts u_asserts (.clk(clk), .rst_n(rst_n),
  .par_pins(par_pins), .host_pins(host_pins),
  .external_memory_port_drive(external_memory_port_drive),
  .host_port_data_oe(host_port_data_oe), .parallel_io_drive(parallel_io_drive),
  .parallel_io_bits(parallel_io_bits), .external_memory_port_clk_en(external_memory_port_clk_en),
  .host_port_en(host_port_en), .bus_select_reg(bus_select_reg));

//--- verif/pin_far_side.sv
// Far side of the shared pins: memory devices and host processor.
// Assumes registered pin drives; a pin left undriven shows the far-side pattern.
module pin_far_side
  import pin_mux_pkg::*;
(
  input wire par_drive_t par_pins,
  input wire host_drive_t host_pins,
  input wire logic [31:0] far_pat,
  output logic [addr_pins-1:0] addr_lvl,
  output logic [data_pins-1:0] data_lvl,
  output logic [ctl_pins-1:0] ctl_lvl,
  output logic [host_data_w-1:0] hd_lvl,
  output logic [host_ctl_w-1:0] hc_lvl
);
  timeunit 1ns;
  timeprecision 1ps;
  assign addr_lvl = (par_pins.addr_out & par_pins.addr_oe) | (far_pat[19:0] & ~par_pins.addr_oe);
  assign data_lvl = (par_pins.data_out & par_pins.data_oe) | (far_pat & ~par_pins.data_oe);
  assign ctl_lvl = (par_pins.ctl_out & par_pins.ctl_oe) | (far_pat[31:16] & ~par_pins.ctl_oe);
  // Host processor shares the eight data pins for address and data
  assign hd_lvl = (host_pins.data_out & host_pins.data_oe) | (far_pat[7:0] & ~host_pins.data_oe);
  assign hc_lvl = (host_pins.ctl_out & host_pins.ctl_oe) | (far_pat[9:8] & ~host_pins.ctl_oe);
endmodule : pin_far_side

//--- verif/parallel_host_pin_mux_tb.sv
// Self-checking bench for the pin multiplexers in both strap modes.
// Assumes the far-side model resolves the pins.
module parallel_host_pin_mux_tb;
  timeunit 1ns;
  timeprecision 1ps;
  import pin_mux_pkg::*;
`define CHK(g, e) cmp_count++; if ((g) !== (e)) begin err_count++; \
  $display("Error %0t got %h exp %h", $time, g, e); end
  localparam logic [45:0] iop = 46'h2a5c3e917b06;
  localparam par_drive_t mdrv = {20'h5a3c1, 20'hfffff, 32'hc3a50f96, 32'hffff0000,
    16'h9e37, 16'h7ff7};
  logic clk, rst_n, strap, clk_en, has, hbi, hpe, bsr;
  logic [31:0] far_pat, mdi;
  logic [19:0] al, mai;
  logic [31:0] dl;
  logic [15:0] cl, mci;
  logic [7:0] hd, hp_out, hp_oe, hdi;
  logic [1:0] hc;
  logic [45:0] io_bits;
  par_drive_t par_pins, mem_drv;
  host_drive_t host_pins;
  io_drive_t io_drv;
  int err_count = 0;
  int cmp_count = 0;
  pin_far_side far (.par_pins(par_pins), .host_pins(host_pins), .far_pat(far_pat),
    .addr_lvl(al), .data_lvl(dl), .ctl_lvl(cl), .hd_lvl(hd), .hc_lvl(hc));
  parallel_host_pin_mux dut (.clk(clk), .rst_n(rst_n), .mode_strap_pin(strap),
    .addr_pin_in(al), .data_pin_in(dl), .ctl_pin_in(cl), .host_data_pins_in(hd),
    .host_ctl_pins_in(hc), .par_pins(par_pins), .host_pins(host_pins),
    .external_memory_port_drive(mem_drv), .mem_addr_in(mai), .mem_data_in(mdi),
    .mem_ctl_in(mci), .external_memory_port_clk_en(clk_en), .host_port_data_out(hp_out),
    .host_port_data_oe(hp_oe), .host_port_data_in(hdi), .host_addr_strobe(has),
    .host_byte_ident(hbi), .host_port_en(hpe), .parallel_io_drive(io_drv),
    .parallel_io_bits(io_bits), .bus_select_reg(bsr));
  ////////////////////////////////////////////////////////////////////////////
  task automatic do_reset(input logic s);
    @(posedge clk);
    rst_n <= 1'b0;
    strap <= s;
    repeat (10) @(posedge clk);
    rst_n <= 1'b1;
    repeat (10) @(posedge clk);
  endtask : do_reset
  task automatic test_io_mode;
    do_reset(1'b0);
    io_drv <= 92'h0;
    far_pat <= 32'h9c3e5a71;
    repeat (6) @(posedge clk);
    #1;
    `CHK({bsr, hpe, clk_en}, 3'h0)
    `CHK({mdi, hdi, has, hbi}, 42'h0)
    `CHK(io_bits, {far_pat[9:0], far_pat[31:16], far_pat[31:16], far_pat[19:16]})
    @(posedge clk);
    io_drv <= {iop, {46{1'b1}}};
    repeat (6) @(posedge clk);
    #1;
    `CHK({par_pins.addr_out, par_pins.data_out}, {iop[3:0], 16'h0, iop[19:4], 16'h0})
    `CHK({par_pins.addr_oe, par_pins.data_oe}, {4'hf, 16'h0, 16'hffff, 16'h0})
    `CHK(par_pins.ctl_out, iop[35:20])
    `CHK(host_pins, {iop[43:36], 8'hff, iop[45:44], 2'h3})
    `CHK(io_bits, iop)
  endtask : test_io_mode
  task automatic test_mem_mode;
    do_reset(1'b1);
    mem_drv <= mdrv;
    hp_out <= 8'h6d;
    hp_oe <= 8'h0f;
    far_pat <= 32'h36c9a5e2;
    repeat (6) @(posedge clk);
    #1;
    `CHK({bsr, hpe, clk_en}, 3'h7)
    `CHK(par_pins, mdrv)
    `CHK({mai, mdi}, {20'h5a3c1, 16'hc3a5, far_pat[15:0]})
    `CHK(mci, (16'h9e37 & 16'h7ff7) | (far_pat[31:16] & 16'h8008))
    `CHK({host_pins.data_out, host_pins.data_oe, host_pins.ctl_oe}, 18'h1b43c)
    `CHK({hdi, has, hbi}, {8'h0d | (far_pat[7:0] & 8'hf0), far_pat[8], far_pat[9]})
    `CHK(io_bits, 46'h0)
  endtask : test_mem_mode
  task automatic test_strap_hold;
    // Only the strap moves after release; nothing tries to rewrite the mode
    strap <= 1'b0;
    repeat (20) @(posedge clk);
    #1;
    `CHK({bsr, clk_en, io_bits}, {2'h3, 46'h0})
  endtask : test_strap_hold
  task automatic end_of_test;
    if (err_count == 0 && cmp_count > 0)
    begin
      $display("SIMULATION PASSED");
    end
    else
    begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask : end_of_test
  initial
  begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end
  initial
  begin
    #5000;
    err_count++;
    end_of_test;
  end
  initial
  begin
    rst_n = 1'b0;
    strap = 1'b0;
    far_pat = 32'h0;
    mem_drv = 136'h0;
    hp_out = 8'h0;
    hp_oe = 8'h0;
    io_drv = 92'h0;
    test_io_mode;
    test_mem_mode;
    test_strap_hold;
    test_io_mode;
    end_of_test;
  end
endmodule : parallel_host_pin_mux_tb
